//--- core/imc_cfg.svh
`ifndef IMC_CFG_SVH
`define IMC_CFG_SVH

// register address, seven-bit frame address field
`define IMC_ADDR_W        7
`define IMC_MASK_ADDR     7'h09
// register layout and reset values
`define IMC_REG_W         16
`define IMC_MASK_POR      16'h0140
`define IMC_MASK_KEEP     16'h01FF
`define IMC_CYC_EN_BIT    8
`define IMC_WD_OFF_BIT    7
`define IMC_WD_FAIL_BIT   6
`define IMC_SER_BIT       5
`define IMC_BD_BIT        4
`define IMC_HS_BIT        3
`define IMC_BUS_BIT       2
`define IMC_TEMP_BIT      1
`define IMC_SUPPLY_BIT    0
`define IMC_EVT_W         7
// timing, pulse and gap times in ns, repeat period in us, counts derived at 25 MHz
`define IMC_CLK_NS        40
`define IMC_PULSE_NS      2000
`define IMC_GAP_NS        2000
`define IMC_PULSE_CYC     ((`IMC_PULSE_NS + `IMC_CLK_NS - 1) / `IMC_CLK_NS)
`define IMC_GAP_CYC       ((`IMC_GAP_NS + `IMC_CLK_NS - 1) / `IMC_CLK_NS)
`define IMC_PERIOD_US     10000
`define IMC_CNT_W         20

`endif

//--- core/imc_pkg.sv
package imc_pkg;

	// interrupt pin sequencer
	typedef enum logic [1:0] {
		IMC_IDLE = 2'b00,
		IMC_LOW  = 2'b01,
		IMC_GAP  = 2'b10
	} imc_state_t;

endpackage

//--- core/imc_mask_ctrl.sv
`timescale 1ns/1ps
`include "imc_cfg.svh"
// Behaviour
// - upper bits read zero, writes ignored
// - repeat events periodically while interrupts pending
// - watchdog-off bit disables watchdog in devmode
// - watchdog failure in devmode raises event
// - spi or crc failure raises event
// - bridge driver summary raises event
// - high-side summary raises event
// - bus summary raises event
// - temperature summary raises event
// - supply summary raises event
// - occurrences during a pulse or gap merge into one held pin event
// - power-on or soft reset loads 0x0140
// - restart keeps low nine bits

module imc_mask_ctrl #(
	parameter int PERIOD_CYC = (`IMC_PERIOD_US * 1000) / `IMC_CLK_NS
) (
	// clock and reset
	input  wire logic                     core_clk,
	input  wire logic                     rstn,
	// decoded serial frame access
	input  wire logic                     frame_wr,
	input  wire logic                     frame_rd,
	input  wire logic                     frame_ok,
	input  wire logic [`IMC_ADDR_W-1:0]   frame_addr,
	input  wire logic [`IMC_REG_W-1:0]    frame_wdata,
	output logic      [`IMC_REG_W-1:0]    frame_rdata,
	// reset kinds
	input  wire logic                     soft_reset,
	input  wire logic                     restart,
	// status events, one-cycle pulses
	input  wire logic                     supply_summary,
	input  wire logic                     temp_summary,
	input  wire logic                     bus_summary,
	input  wire logic                     high_side_summary,
	input  wire logic                     bridge_driver_summary,
	input  wire logic                     spi_fail,
	input  wire logic                     crc_fail,
	input  wire logic                     watchdog_fail,
	// mode and pending level
	input  wire logic                     devmode,
	input  wire logic                     int_pending,
	// outputs
	output logic                          interrupt_output_low,
	output logic                          watchdog_enable
);

	// ****************************************
	// reset release
	// ****************************************
	logic rst_s1_reg;
	logic rst_n_reg;

	// async assert, two-stage release to avoid recovery hazards
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_reg <= 1'h0;
			rst_n_reg  <= 1'h0;
		end else begin
			rst_s1_reg <= 1'h1;
			rst_n_reg  <= rst_s1_reg;
		end
	end

	// ****************************************
	// mask register
	// ****************************************
	logic [`IMC_REG_W-1:0] mask_reg;
	logic [`IMC_REG_W-1:0] mask_next;
	logic                  addr_hit;
	logic                  wr_take;

	function automatic logic hit_addr(input logic [`IMC_ADDR_W-1:0] a);
		return a == `IMC_MASK_ADDR;
	endfunction

	assign addr_hit = hit_addr(frame_addr);
	assign wr_take  = frame_wr && frame_ok && addr_hit;

	// soft reset beats restart beats a write
	assign mask_next = soft_reset ? `IMC_MASK_POR :
	                   restart    ? (mask_reg & `IMC_MASK_KEEP) :
	                   wr_take    ? (frame_wdata & `IMC_MASK_KEEP) :
	                                mask_reg;

	// register and read-back
	always_ff @(posedge core_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			mask_reg    <= `IMC_MASK_POR;
			frame_rdata <= '0;
		end else begin
			mask_reg    <= mask_next;
			frame_rdata <= (frame_rd && addr_hit) ? (mask_reg & `IMC_MASK_KEEP) : '0;
		end
	end

	// ****************************************
	// watchdog gate
	// ****************************************
	always_ff @(posedge core_clk or negedge rst_n_reg) begin
		if (!rst_n_reg)
			watchdog_enable <= 1'h1;
		else
			watchdog_enable <= !(devmode && mask_reg[`IMC_WD_OFF_BIT]);
	end

	// ****************************************
	// event masking
	// ****************************************
	logic [`IMC_EVT_W-1:0] evt_vec;
	logic                  evt_hit;
	logic                  per_hit;
	logic                  req_any;

	// vector lines up with mask bits 6..0
	assign evt_vec = {watchdog_fail && devmode,
	                  spi_fail || crc_fail,
	                  bridge_driver_summary,
	                  high_side_summary,
	                  bus_summary,
	                  temp_summary,
	                  supply_summary};
	assign evt_hit = |(evt_vec & mask_reg[`IMC_EVT_W-1:0]);
	assign req_any = evt_hit || per_hit;

	// ****************************************
	// periodic repeat timer
	// ****************************************
	logic [`IMC_CNT_W-1:0] per_cnt_reg;
	logic                  per_run;

	assign per_run = mask_reg[`IMC_CYC_EN_BIT] && int_pending;
	assign per_hit = per_run && (per_cnt_reg == `IMC_CNT_W'(PERIOD_CYC - 1));

	// counter idles at zero whenever repeat is off or nothing pending
	always_ff @(posedge core_clk or negedge rst_n_reg) begin
		if (!rst_n_reg)
			per_cnt_reg <= '0;
		else if (!per_run || per_hit)
			per_cnt_reg <= '0;
		else
			per_cnt_reg <= per_cnt_reg + 1'h1;
	end

	// ****************************************
	// pin sequencer
	// ****************************************
	imc_pkg::imc_state_t   state_reg;
	imc_pkg::imc_state_t   state_next;
	logic [`IMC_CNT_W-1:0] cnt_reg;
	logic [`IMC_CNT_W-1:0] cnt_next;
	logic                  pend_reg;
	logic                  pend_next;
	logic                  take;

	// an event during a pulse or gap is held; several merge into one held request
	assign take      = (state_reg == imc_pkg::IMC_IDLE) && (pend_reg || req_any);
	// a new event meeting the take of a held one stays held: set wins
	assign pend_next = req_any ? (pend_reg || !take) : (pend_reg && !take);

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			imc_pkg::IMC_IDLE: begin
				if (take) begin
					state_next = imc_pkg::IMC_LOW;
					cnt_next   = '0;
				end
			end
			imc_pkg::IMC_LOW: begin
				cnt_next = cnt_reg + 1'h1;
				if (cnt_reg == `IMC_CNT_W'(`IMC_PULSE_CYC - 1)) begin
					state_next = imc_pkg::IMC_GAP;
					cnt_next   = '0;
				end
			end
			imc_pkg::IMC_GAP: begin
				// high gap keeps back-to-back events visible as separate edges
				cnt_next = cnt_reg + 1'h1;
				if (cnt_reg == `IMC_CNT_W'(`IMC_GAP_CYC - 1)) begin
					state_next = imc_pkg::IMC_IDLE;
					cnt_next   = '0;
				end
			end
			default: begin
				state_next = imc_pkg::IMC_IDLE;
				cnt_next   = '0;
			end
		endcase
	end

	// state, counter, held request and pin
	always_ff @(posedge core_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			state_reg            <= imc_pkg::IMC_IDLE;
			cnt_reg              <= '0;
			pend_reg             <= 1'h0;
			interrupt_output_low <= 1'h1;
		end else begin
			state_reg            <= state_next;
			cnt_reg              <= cnt_next;
			pend_reg             <= pend_next;
			interrupt_output_low <= (state_next != imc_pkg::IMC_LOW);
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n_reg);

	property p_upper_zero;
		frame_rd && addr_hit |=> frame_rdata[`IMC_REG_W-1:`IMC_CYC_EN_BIT+1] == '0
			&& frame_rdata[`IMC_CYC_EN_BIT:0] == $past(mask_reg[`IMC_CYC_EN_BIT:0]);
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");

	property p_no_repeat;
		!mask_reg[`IMC_CYC_EN_BIT] |-> !per_hit ##1 (per_cnt_reg == '0);
	endproperty
	a_no_repeat: assert property (p_no_repeat) else $error("repeat while disabled");

	property p_wd_off;
		devmode && mask_reg[`IMC_WD_OFF_BIT] |=> !watchdog_enable;
	endproperty
	a_wd_off: assert property (p_wd_off) else $error("watchdog not disabled");

	property p_wd_evt;
		watchdog_fail && devmode && mask_reg[`IMC_WD_FAIL_BIT]
			&& state_reg == imc_pkg::IMC_IDLE |=> !interrupt_output_low;
	endproperty
	a_wd_evt: assert property (p_wd_evt) else $error("watchdog event lost");

	property p_ser_evt;
		(spi_fail || crc_fail) && mask_reg[`IMC_SER_BIT]
			&& state_reg == imc_pkg::IMC_IDLE |=> !interrupt_output_low;
	endproperty
	a_ser_evt: assert property (p_ser_evt) else $error("serial event lost");

	property p_held;
		evt_hit && state_reg != imc_pkg::IMC_IDLE |=> pend_reg;
	endproperty
	a_held: assert property (p_held) else $error("event dropped in pulse");

	property p_set_wins;
		req_any && pend_reg && take |=> pend_reg;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("held event lost on take");

	property p_soft;
		soft_reset |=> mask_reg == `IMC_MASK_POR;
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset value wrong");

	property p_restart;
		restart && !soft_reset |=> mask_reg == ($past(mask_reg) & `IMC_MASK_KEEP);
	endproperty
	a_restart: assert property (p_restart) else $error("restart lost bits");

	property p_write;
		wr_take && !soft_reset && !restart
			|=> mask_reg == ($past(frame_wdata) & `IMC_MASK_KEEP);
	endproperty
	a_write: assert property (p_write) else $error("write not taken");

	property p_bad_frame;
		frame_wr && !frame_ok && !soft_reset && !restart |=> $stable(mask_reg);
	endproperty
	a_bad_frame: assert property (p_bad_frame) else $error("bad frame wrote");

endmodule // imc_mask_ctrl

//--- dv/imc_mcu_model.sv
`timescale 1ns/1ps
// ****************
// host stand-in: frame strobes out, interrupt pin in
// ****************
module imc_mcu_model (
	// clock
	input  wire logic        core_clk,
	// frame strobes toward the device
	output logic             frame_wr,
	output logic             frame_rd,
	output logic             frame_ok,
	output logic [6:0]       frame_addr,
	output logic [15:0]      frame_wdata,
	// read data and interrupt pin
	input  wire logic [15:0] frame_rdata,
	input  wire logic        interrupt_output_low
);
	int pulses = 0;
	initial begin
		{frame_wr, frame_rd, frame_ok} = 3'h0;
		frame_addr = 7'h00;
		frame_wdata = 16'h0000;
	end
	// each falling pin edge is one event seen by the host
	always @(negedge interrupt_output_low) pulses++;
	// ok low stands for a frame that failed its crc check
	task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic ok);
		@(posedge core_clk) #1;
		frame_wr = 1'b1;
		frame_ok = ok;
		frame_addr = a;
		frame_wdata = d;
		@(posedge core_clk) #1;
		frame_wr = 1'b0;
		frame_ok = 1'b0;
		frame_wdata = ~d; // released bus must not keep old data
	endtask
	// data is registered, so it is taken one edge after the strobe
	task automatic rd(input logic [6:0] a, output logic [15:0] d);
		@(posedge core_clk) #1;
		frame_rd = 1'b1;
		frame_addr = a;
		@(posedge core_clk) #1;
		frame_rd = 1'b0;
		d = frame_rdata;
	endtask
endmodule // imc_mcu_model

//--- dv/imc_mask_ctrl_test.sv
`timescale 1ns/1ps
`include "imc_cfg.svh"
module imc_mask_ctrl_test;
	logic        core_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        soft_reset = 1'b0, restart = 1'b0, devmode = 1'b0, int_pending = 1'b0;
	logic [7:0]  ev = 8'h00;
	logic        frame_wr, frame_rd, frame_ok, interrupt_output_low, watchdog_enable;
	logic [6:0]  frame_addr;
	logic [15:0] frame_wdata, frame_rdata, rv;
	int          err_total = 0, check_count = 0, p;
	imc_mask_ctrl #(.PERIOD_CYC(200)) i_imc_mask_ctrl (.core_clk(core_clk), .rstn(rstn),
		.frame_wr(frame_wr), .frame_rd(frame_rd), .frame_ok(frame_ok),
		.frame_addr(frame_addr), .frame_wdata(frame_wdata), .frame_rdata(frame_rdata),
		.soft_reset(soft_reset), .restart(restart), .supply_summary(ev[0]),
		.temp_summary(ev[1]), .bus_summary(ev[2]), .high_side_summary(ev[3]),
		.bridge_driver_summary(ev[4]), .spi_fail(ev[5]), .crc_fail(ev[7]),
		.watchdog_fail(ev[6]), .devmode(devmode), .int_pending(int_pending),
		.interrupt_output_low(interrupt_output_low), .watchdog_enable(watchdog_enable));
	imc_mcu_model i_imc_mcu_model (.core_clk(core_clk), .frame_wr(frame_wr),
		.frame_rd(frame_rd), .frame_ok(frame_ok), .frame_addr(frame_addr),
		.frame_wdata(frame_wdata), .frame_rdata(frame_rdata),
		.interrupt_output_low(interrupt_output_low));
	initial forever #20 core_clk = ~core_clk;
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic rdchk(input logic [15:0] exp);
		i_imc_mcu_model.rd(`IMC_MASK_ADDR, rv);
		chk(rv, exp);
	endtask
	task automatic fire(input int i);
		@(posedge core_clk) #1;
		ev[i] = 1'b1;
		@(posedge core_clk) #1;
		ev[i] = 1'b0;
	endtask
	task automatic t_regs();
		rdchk(16'h0140);
		i_imc_mcu_model.wr(`IMC_MASK_ADDR, 16'hFFFF, 1'b1);
		rdchk(16'h01FF);
		i_imc_mcu_model.wr(`IMC_MASK_ADDR, 16'h0000, 1'b0);
		rdchk(16'h01FF);
		i_imc_mcu_model.wr(7'h0A, 16'h0000, 1'b1);
		i_imc_mcu_model.rd(7'h0A, rv);
		chk(rv, 16'h0000);
		rdchk(16'h01FF);
	endtask
	// every source alone, enabled then masked; crc shares the serial bit
	task automatic t_events();
		int b;
		devmode = 1'b1;
		for (int i = 0; i < 8; i++) begin
			b = (i == 7) ? 5 : i;
			i_imc_mcu_model.wr(`IMC_MASK_ADDR, 16'h0001 << b, 1'b1);
			p = i_imc_mcu_model.pulses;
			fire(i);
			cyc(110);
			chk(i_imc_mcu_model.pulses - p, 16'h0001);
			i_imc_mcu_model.wr(`IMC_MASK_ADDR, 16'h00FF ^ (16'h0001 << b), 1'b1);
			p = i_imc_mcu_model.pulses;
			fire(i);
			cyc(110);
			chk(i_imc_mcu_model.pulses - p, 16'h0000);
		end
	endtask
	task automatic t_repeat();
		i_imc_mcu_model.wr(`IMC_MASK_ADDR, 16'h0004, 1'b1);
		p = i_imc_mcu_model.pulses;
		fire(2);
		cyc(110);
		fire(2);
		cyc(110);
		chk(i_imc_mcu_model.pulses - p, 16'h0002);
		// second event lands inside the first pulse and must be held
		p = i_imc_mcu_model.pulses;
		fire(2);
		cyc(5);
		fire(2);
		cyc(220);
		chk(i_imc_mcu_model.pulses - p, 16'h0002);
	endtask
	task automatic t_watchdog();
		i_imc_mcu_model.wr(`IMC_MASK_ADDR, 16'h0080, 1'b1);
		cyc(2);
		chk(watchdog_enable, 1'b0);
		devmode = 1'b0;
		cyc(2);
		chk(watchdog_enable, 1'b1);
		devmode = 1'b1;
		i_imc_mcu_model.wr(`IMC_MASK_ADDR, 16'h0000, 1'b1);
		cyc(2);
		chk(watchdog_enable, 1'b1);
	endtask
	// ticks every 200 cycles, so 520 cycles hold two of them
	task automatic t_periodic();
		i_imc_mcu_model.wr(`IMC_MASK_ADDR, 16'h0100, 1'b1);
		int_pending = 1'b1;
		p = i_imc_mcu_model.pulses;
		cyc(520);
		chk(i_imc_mcu_model.pulses - p, 16'h0002);
		i_imc_mcu_model.wr(`IMC_MASK_ADDR, 16'h0000, 1'b1);
		p = i_imc_mcu_model.pulses;
		cyc(450);
		chk(i_imc_mcu_model.pulses - p, 16'h0000);
		int_pending = 1'b0;
	endtask
	task automatic t_resets();
		i_imc_mcu_model.wr(`IMC_MASK_ADDR, 16'hFEAB, 1'b1);
		restart = 1'b1;
		cyc(1);
		restart = 1'b0;
		rdchk(16'h00AB);
		soft_reset = 1'b1;
		cyc(1);
		soft_reset = 1'b0;
		rdchk(16'h0140);
	endtask
	task automatic tally_and_finish();
		if (err_total == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		cyc(6);
		rstn = 1'b1;
		cyc(3);
		t_regs();
		t_events();
		t_repeat();
		t_watchdog();
		t_periodic();
		t_resets();
		tally_and_finish();
	end
	// run needs about 3300 cycles
	initial begin
		#400000;
		err_total++;
		tally_and_finish();
	end
endmodule // imc_mask_ctrl_test
